// File: eelc_pkg.sv
/*
 package of the edge event line controller: sizes, register offsets,
 field layout and reset values.
 assumes a 32-bit apb bus with byte addresses on paddr.
*/
`default_nettype none
package eelc_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_LINES = 24;
   localparam int NUM_EXT = 16;
   localparam int NUM_INT = NUM_LINES - NUM_EXT;
   localparam int NUM_PINS = 55;
   localparam int SEL_W = 6;
   localparam int SEL_FIELD_W = 8;
   localparam int SEL_PER_WORD = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RISE_SEL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FALL_SEL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PIN_SEL0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_PIN_SEL1 = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_PIN_SEL2 = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_PIN_SEL3 = 8'h2C;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [NUM_LINES-1:0] RST_LINES = 24'h00_0000;
   localparam logic [SEL_W-1:0] RST_SEL = 6'h00;
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// File: eelc_edge_cap.sv
/*
 edge capture of one line: toggle flops clocked by the line itself, so
 pulses shorter than a ref_clk period are caught, then a two-flop
 synchroniser and an edge compare in the ref_clk domain.
 assumes the line is glitch free; nrst also clears the toggle flops
 asynchronously since those have no clock of their own to use.
*/
`default_nettype none
module eelc_edge_cap (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // line
   input wire logic line_in,
   // one-cycle pulses in ref_clk domain
   output logic rise_pulse,
   output logic fall_pulse
);
   logic rise_tog_ff;
   logic fall_tog_ff;
   logic [2:0] rise_sync_ff;
   logic [2:0] fall_sync_ff;
   logic [2:0] nxt_rise_sync;
   logic [2:0] nxt_fall_sync;

   // ---------------------------------------------------------------
   // clockless capture
   // ---------------------------------------------------------------
   always_ff @(posedge line_in or negedge nrst)
   begin
      if (!nrst)
         rise_tog_ff <= 1'b0;
      else
         rise_tog_ff <= ~rise_tog_ff; // RULE6
   end

   always_ff @(negedge line_in or negedge nrst)
   begin
      if (!nrst)
         fall_tog_ff <= 1'b0;
      else
         fall_tog_ff <= ~fall_tog_ff; // RULE6
   end

   // ---------------------------------------------------------------
   // synchroniser
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_rise_sync = {rise_sync_ff[1:0], rise_tog_ff};
      nxt_fall_sync = {fall_sync_ff[1:0], fall_tog_ff};
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rise_sync_ff <= 3'h0;
         fall_sync_ff <= 3'h0;
      end
      else if (ce)
      begin
         rise_sync_ff <= nxt_rise_sync;
         fall_sync_ff <= nxt_fall_sync;
      end
   end

   assign rise_pulse = ce & (rise_sync_ff[2] ^ rise_sync_ff[1]);
   assign fall_pulse = ce & (fall_sync_ff[2] ^ fall_sync_ff[1]);
endmodule
`default_nettype wire

// File: eelc_pin_mux.sv
/*
 pin selection for the external lines: each external line takes one
 gpio pin picked by its select field.
 assumes select values of the pin count or above pick no pin (low).
*/
`default_nettype none
module eelc_pin_mux (
   // gpio pins
   input wire logic [eelc_pkg::NUM_PINS-1:0] gpio_pins,
   // selects, one field per line
   input wire logic [eelc_pkg::NUM_EXT*eelc_pkg::SEL_W-1:0] pin_sel,
   // selected lines
   output logic [eelc_pkg::NUM_EXT-1:0] ext_lines
);
   genvar g;
   generate
      for (g = 0; g < eelc_pkg::NUM_EXT; g++)
      begin : g_line
         logic [eelc_pkg::SEL_W-1:0] sel;
         assign sel = pin_sel[g*eelc_pkg::SEL_W +: eelc_pkg::SEL_W];
         assign ext_lines[g] = (int'(sel) < eelc_pkg::NUM_PINS) ? gpio_pins[sel] : 1'b0; // RULE7
      end
   endgenerate
endmodule
`default_nettype wire

// File: eelc_top.sv
/*
 edge event line controller: edge detection on 24 lines, trigger edge
 selection, interrupt and event masks, sticky pending bits, interrupt,
 event and wake-up outputs, apb register slave.
 assumes apb master keeps the request stable until pready; ref_clk at
 250 MHz; gpio pins and internal event sources glitch free.
*/
// The placing of the registers and register access over APB were left to the implementer.
// Functional notes
// (RULE1) twenty-four edge lines, each raising an interrupt or event request.
// (RULE2) any triggered enabled line raises the wake-up request.
// (RULE3) per line rising, falling or both edges; only selected edges trigger.
// (RULE4) per line masks; a masked line forwards no request.
// (RULE5) per line pending bit records interrupt requests, readable by software.
// (RULE6) edges captured without clock sampling, catching pulses shorter than a clock.
// (RULE7) sixteen external lines, each fed by one of fifty-five selectable pins.
// (RULE8) pending stays set until software writes one to it.
`default_nettype none
module eelc_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [eelc_pkg::ADDR_W-1:0] paddr,
   input wire logic [eelc_pkg::DATA_W-1:0] pwdata,
   output logic [eelc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // sources
   input wire logic [eelc_pkg::NUM_PINS-1:0] gpio_pins,
   input wire logic [eelc_pkg::NUM_INT-1:0] periph_events,
   // requests
   output logic [eelc_pkg::NUM_LINES-1:0] line_irq,
   output logic [eelc_pkg::NUM_LINES-1:0] line_evt,
   output logic irq,
   output logic wakeup_req
);
   localparam int NL = eelc_pkg::NUM_LINES;
   localparam int NE = eelc_pkg::NUM_EXT;
   localparam int SW = eelc_pkg::SEL_W;
   localparam int FW = eelc_pkg::SEL_FIELD_W;
   localparam int DW = eelc_pkg::DATA_W;
   localparam int SPW = eelc_pkg::SEL_PER_WORD;

   logic [NL-1:0] int_mask_ff, nxt_int_mask;
   logic [NL-1:0] evt_mask_ff, nxt_evt_mask;
   logic [NL-1:0] rise_sel_ff, nxt_rise_sel;
   logic [NL-1:0] fall_sel_ff, nxt_fall_sel;
   logic [NL-1:0] pend_ff, nxt_pend;
   logic [NL-1:0] evt_ff, nxt_evt;
   logic [NE*SW-1:0] pin_sel_ff, nxt_pin_sel;
   logic [DW-1:0] rdata_ff, nxt_rdata;
   logic [NL-1:0] lines, rise_p, fall_p, trig, clr_vec;
   logic [NE-1:0] ext_lines;
   logic [DW-1:0] rd_mux;
   logic wr_en, acc, hit;

   // ---------------------------------------------------------------
   // line sources and edge capture
   // ---------------------------------------------------------------
   eelc_pin_mux u_mux (
      .gpio_pins(gpio_pins),
      .pin_sel(pin_sel_ff),
      .ext_lines(ext_lines)
   );

   assign lines = {periph_events, ext_lines}; // RULE7

   genvar g;
   generate
      for (g = 0; g < NL; g++)
      begin : g_cap
         eelc_edge_cap u_cap (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .ce(ce),
            .line_in(lines[g]),
            .rise_pulse(rise_p[g]),
            .fall_pulse(fall_p[g])
         ); // RULE1 RULE6
      end
   endgenerate

   assign trig = (rise_p & rise_sel_ff) | (fall_p & fall_sel_ff); // RULE3

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   assign acc = psel & penable;
   assign wr_en = acc & pwrite & ce;

   always_comb
   begin
      hit = 1'b1;
      rd_mux = eelc_pkg::RST_DATA;
      case (paddr)
         eelc_pkg::OFS_INT_MASK: rd_mux[NL-1:0] = int_mask_ff;
         eelc_pkg::OFS_EVT_MASK: rd_mux[NL-1:0] = evt_mask_ff;
         eelc_pkg::OFS_RISE_SEL: rd_mux[NL-1:0] = rise_sel_ff;
         eelc_pkg::OFS_FALL_SEL: rd_mux[NL-1:0] = fall_sel_ff;
         eelc_pkg::OFS_PENDING: rd_mux[NL-1:0] = pend_ff; // RULE5
         eelc_pkg::OFS_PIN_SEL0, eelc_pkg::OFS_PIN_SEL1,
         eelc_pkg::OFS_PIN_SEL2, eelc_pkg::OFS_PIN_SEL3:
         begin
            for (int k = 0; k < eelc_pkg::SEL_PER_WORD; k++)
               rd_mux[k*FW +: SW] = pin_sel_ff[(int'(paddr[3:2])*SPW + k)*SW +: SW];
         end
         default: hit = 1'b0;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata = rdata_ff;

   // ---------------------------------------------------------------
   // register next values
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_int_mask = int_mask_ff;
      nxt_evt_mask = evt_mask_ff;
      nxt_rise_sel = rise_sel_ff;
      nxt_fall_sel = fall_sel_ff;
      nxt_pin_sel = pin_sel_ff;
      clr_vec = eelc_pkg::RST_LINES;
      nxt_rdata = (psel & ~penable & ~pwrite) ? rd_mux : rdata_ff;
      if (wr_en)
      begin
         case (paddr)
            eelc_pkg::OFS_INT_MASK: nxt_int_mask = pwdata[NL-1:0];
            eelc_pkg::OFS_EVT_MASK: nxt_evt_mask = pwdata[NL-1:0];
            eelc_pkg::OFS_RISE_SEL: nxt_rise_sel = pwdata[NL-1:0];
            eelc_pkg::OFS_FALL_SEL: nxt_fall_sel = pwdata[NL-1:0];
            eelc_pkg::OFS_PENDING: clr_vec = pwdata[NL-1:0]; // RULE8
            eelc_pkg::OFS_PIN_SEL0, eelc_pkg::OFS_PIN_SEL1,
            eelc_pkg::OFS_PIN_SEL2, eelc_pkg::OFS_PIN_SEL3:
            begin
               for (int k = 0; k < eelc_pkg::SEL_PER_WORD; k++)
                  nxt_pin_sel[(int'(paddr[3:2])*SPW + k)*SW +: SW] = pwdata[k*FW +: SW];
            end
            default: clr_vec = eelc_pkg::RST_LINES;
         endcase
      end
      // set wins over a clear in the same cycle
      nxt_pend = (pend_ff & ~clr_vec) | (trig & int_mask_ff); // RULE4 RULE5 RULE8
      nxt_evt = trig & evt_mask_ff; // RULE4
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         int_mask_ff <= eelc_pkg::RST_LINES;
         evt_mask_ff <= eelc_pkg::RST_LINES;
         rise_sel_ff <= eelc_pkg::RST_LINES;
         fall_sel_ff <= eelc_pkg::RST_LINES;
         pend_ff <= eelc_pkg::RST_LINES;
         evt_ff <= eelc_pkg::RST_LINES;
         pin_sel_ff <= {NE{eelc_pkg::RST_SEL}};
         rdata_ff <= eelc_pkg::RST_DATA;
      end
      else if (ce)
      begin
         int_mask_ff <= nxt_int_mask;
         evt_mask_ff <= nxt_evt_mask;
         rise_sel_ff <= nxt_rise_sel;
         fall_sel_ff <= nxt_fall_sel;
         pend_ff <= nxt_pend;
         evt_ff <= nxt_evt;
         pin_sel_ff <= nxt_pin_sel;
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // request outputs
   // ---------------------------------------------------------------
   assign line_irq = pend_ff & int_mask_ff; // RULE1 RULE4
   assign line_evt = evt_ff; // RULE1
   assign irq = |line_irq;
   assign wakeup_req = irq | (|evt_ff); // RULE2

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic [NL-1:0] keep_vec;
   assign keep_vec = pend_ff & ~clr_vec;

   sequence s_write_pending;
      wr_en && paddr == eelc_pkg::OFS_PENDING;
   endsequence

   a_pend_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
      ce |=> ((pend_ff & ~$past(pend_ff) & ~$past(trig & int_mask_ff)) == 0)) // RULE5
      else $error("pending bit set without an enabled trigger");

   a_pend_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
      1 |=> (($past(keep_vec) & ~pend_ff) == 0)) // RULE8
      else $error("pending bit dropped without a clearing write");

   a_pend_w1c: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_write_pending ##0 ((pwdata[NL-1:0] & ~(trig & int_mask_ff)) != 0)
      |=> ((pend_ff & $past(pwdata[NL-1:0] & ~(trig & int_mask_ff))) == 0)) // RULE8
      else $error("write of one did not clear the pending bit");

   a_irq_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
      ce |=> ((pend_ff & ~$past(pend_ff) & ~$past(int_mask_ff)) == 0)) // RULE4
      else $error("pending set on a masked line");

   a_evt_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
      ce |=> ((line_evt & ~$past(evt_mask_ff)) == 0)) // RULE4
      else $error("event forwarded by a masked line");

   a_wake_on_req: assert property (@(posedge ref_clk) disable iff (!nrst)
      (irq || line_evt != 0) |-> wakeup_req) // RULE2
      else $error("request without wake-up");

   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!nrst)
      (acc && !hit) |-> (pslverr && pready)) // RULE5
      else $error("unmapped access not flagged");

   a_pslverr_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
      !acc |-> !pslverr) // RULE5
      else $error("error response outside an access phase");

   a_unsel_no_pend: assert property (@(posedge ref_clk) disable iff (!nrst)
      ce |=> ((pend_ff & ~$past(pend_ff) & ~$past(rise_sel_ff | fall_sel_ff)) == 0)) // RULE3
      else $error("pending set on a line with no edge selected");

   a_evt_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
      ce |=> ((line_evt & ~$past(rise_sel_ff | fall_sel_ff)) == 0)) // RULE3
      else $error("event on a line with no edge selected");

   a_ce_freeze: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ce |=> ($stable(pend_ff) && $stable(prdata))) // RULE8
      else $error("state moved while clock enable was low");

   // ---------------------------------------------------------------
   // assertions on register access and on internal line edges
   // ---------------------------------------------------------------
   sequence s_write_int_mask;
      wr_en && paddr == eelc_pkg::OFS_INT_MASK;
   endsequence

   sequence s_write_evt_mask;
      wr_en && paddr == eelc_pkg::OFS_EVT_MASK;
   endsequence

   sequence s_write_lost;
      psel && penable && pwrite && !ce;
   endsequence

   sequence s_read_pending;
      ce && psel && !penable && !pwrite && paddr == eelc_pkg::OFS_PENDING;
   endsequence

   a_int_mask_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_write_int_mask |=> (int_mask_ff == $past(pwdata[NL-1:0]))) // RULE4
      else $error("interrupt mask write did not land");

   a_evt_mask_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_write_evt_mask |=> (evt_mask_ff == $past(pwdata[NL-1:0]))) // RULE4
      else $error("event mask write did not land");

   a_frozen_cfg: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_write_lost |=> ($stable(int_mask_ff) && $stable(evt_mask_ff))) // RULE4
      else $error("write with clock enable low changed a mask");

   a_read_load: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_read_pending |=> (prdata[NL-1:0] == $past(pend_ff))) // RULE5
      else $error("pending read did not return the pending bits");

   generate
      for (g = NE; g < NL; g++)
      begin : g_chk
         sequence s_rise_armed;
            ce && $rose(lines[g]) && rise_sel_ff[g] && int_mask_ff[g];
         endsequence

         sequence s_fall_armed;
            ce && $fell(lines[g]) && fall_sel_ff[g] && int_mask_ff[g];
         endsequence

         a_int_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
            s_rise_armed
            ##1 (ce && rise_sel_ff[g] && int_mask_ff[g] && !(wr_en)) [*4]
            |-> ##[0:1] pend_ff[g]) // RULE3 RULE6
            else $error("selected rising edge did not set pending");

         a_int_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
            s_fall_armed
            ##1 (ce && fall_sel_ff[g] && int_mask_ff[g] && !(wr_en)) [*4]
            |-> ##[0:1] pend_ff[g]) // RULE3 RULE6
            else $error("selected falling edge did not set pending");
      end
   endgenerate
endmodule
`default_nettype wire

// File: eelc_src_model.sv
/*
 source model: gpio pins and peripheral event lines of the edge event
 line controller. assumes the bench calls its tasks from its main flow.
*/
`default_nettype none
module eelc_src_model (
   // clock
   input wire logic ref_clk,
   // sources
   output logic [eelc_pkg::NUM_PINS-1:0] gpio_pins,
   output logic [eelc_pkg::NUM_INT-1:0] periph_events
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      gpio_pins = '0;
      periph_events = '0;
   end
   task pin(input int p, input logic v);
      @(posedge ref_clk);
      gpio_pins[p] <= v;
   endtask
   task evt(input logic [7:0] v);
      @(posedge ref_clk);
      periph_events <= v;
   endtask
   // high pulse of 1 ns, shorter than one clock period
   task glitch(input int p);
      @(posedge ref_clk);
      #1 gpio_pins[p] = 1'b1;
      #1 gpio_pins[p] = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: eelc_top_test.sv
/*
 testbench of the edge event line controller: apb master, expected
 read queue with a watching process, line stimulus via the source model.
 assumes zero wait apb slave and line latency under 8 cycles.
*/
`default_nettype none
module eelc_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, nrst, ce, psel, penable, pwrite, pready, pslverr, irq, wakeup_req;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [54:0] gpio_pins;
   logic [7:0] periph_events, r, prev, exp_l;
   logic [23:0] line_irq, line_evt;
   logic [32:0] exp_q[$];
   logic [7:0] ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C};
   int err_total = 0, cmp_count = 0, seed = 91794, evt_cnt = 0, e0;
   eelc_top DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gpio_pins(gpio_pins), .periph_events(periph_events),
      .line_irq(line_irq), .line_evt(line_evt), .irq(irq), .wakeup_req(wakeup_req));
   eelc_src_model src (.ref_clk(ref_clk), .gpio_pins(gpio_pins), .periph_events(periph_events));
   // -----------------
   // checks
   // -----------------
   task chk(input string n, input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk("read", exp_q.pop_front(), {pslverr, prdata});
      evt_cnt <= evt_cnt + $countones(line_evt);
   end
   // -----------------
   // apb master
   // -----------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
      begin
         chk("pready", 33'h1, 33'(pready));
         end_of_test();
      end
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task lines(input logic [23:0] e);
      repeat (8) @(posedge ref_clk);
      chk("line_irq", 33'(e), 33'(line_irq));
      chk("irq", 33'(e != 0), 33'(irq));
      chk("wakeup", 33'(e != 0), 33'(wakeup_req));
      rd(eelc_pkg::OFS_PENDING, 33'(e));
      apb(1'b1, eelc_pkg::OFS_PENDING, 32'hFFFF_FFFF);
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      end_of_test();
   end
   // -----------------
   // tests
   // -----------------
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (ofs[i]) rd(ofs[i], 33'h0_0000_0000);
      rd(8'h10, 33'h1_0000_0000);
      $display("test reset done");
      apb(1'b1, eelc_pkg::OFS_INT_MASK, 32'hFFFF_FFFF);
      rd(eelc_pkg::OFS_INT_MASK, 33'h0_00FF_FFFF);
      apb(1'b1, eelc_pkg::OFS_PIN_SEL3, 32'hFFFF_FFFF);
      rd(eelc_pkg::OFS_PIN_SEL3, 33'h0_3F3F_3F3F);
      ce <= 1'b0;
      apb(1'b1, eelc_pkg::OFS_EVT_MASK, 32'hFFFF_FFFF);
      ce <= 1'b1;
      rd(eelc_pkg::OFS_EVT_MASK, 33'h0_0000_0000);
      $display("test registers done");
      apb(1'b1, eelc_pkg::OFS_PIN_SEL0, 32'h0000_0036);
      apb(1'b1, eelc_pkg::OFS_RISE_SEL, 32'h0000_0001);
      apb(1'b1, eelc_pkg::OFS_EVT_MASK, 32'h0000_0001);
      e0 = evt_cnt;
      src.pin(54, 1'b1);
      lines(24'h00_0001);
      rd(eelc_pkg::OFS_PENDING, 33'h0_0000_0000);
      src.pin(54, 1'b0);
      lines(24'h00_0000);
      apb(1'b1, eelc_pkg::OFS_INT_MASK, 32'h0000_0000);
      src.pin(54, 1'b1);
      lines(24'h00_0000);
      chk("events", 33'h2, 33'(evt_cnt - e0));
      src.pin(54, 1'b0);
      apb(1'b1, eelc_pkg::OFS_INT_MASK, 32'hFFFF_FFFF);
      src.glitch(54);
      lines(24'h00_0001);
      apb(1'b1, eelc_pkg::OFS_PIN_SEL0, 32'h0000_0037);
      src.pin(54, 1'b1);
      lines(24'h00_0000);
      $display("test pins done");
      apb(1'b1, eelc_pkg::OFS_RISE_SEL, 32'h00FF_0000);
      prev = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (i == 8)
         begin
            apb(1'b1, eelc_pkg::OFS_RISE_SEL, 32'h0000_0000);
            apb(1'b1, eelc_pkg::OFS_FALL_SEL, 32'h00FF_0000);
         end
         if (i == 12)
            apb(1'b1, eelc_pkg::OFS_RISE_SEL, 32'h00FF_0000);
         r = 8'($random(seed));
         src.evt(r);
         if (i < 8)
            exp_l = r & ~prev;
         else if (i < 12)
            exp_l = ~r & prev;
         else
            exp_l = r ^ prev;
         lines({exp_l, 16'h0000});
         prev = r;
      end
      $display("test internal lines done");
      end_of_test();
   end
endmodule
`default_nettype wire
